// >>> shift_logic_pkg.sv
package shift_logic_pkg;

  // opcode patterns, size bit masked off
  localparam logic [6:0] OP_SHIFT_ONE   = 7'h68;  // 1101000w
  localparam logic [6:0] OP_SHIFT_CNT   = 7'h69;  // 1101001w
  localparam logic [6:0] OP_SHIFT_IMM   = 7'h60;  // 1100000w
  localparam logic [7:0] OP_ESCAPE      = 8'h0f;  // two-byte prefix
  localparam logic [7:0] OP_DSHL_IMM    = 8'ha4;
  localparam logic [7:0] OP_DSHL_CNT    = 8'ha5;
  localparam logic [7:0] OP_DSHR_IMM    = 8'hac;
  localparam logic [7:0] OP_DSHR_CNT    = 8'had;
  localparam logic [5:0] OP_AND_RR      = 6'h08;  // 001000dw
  localparam logic [6:0] OP_AND_ACC     = 7'h12;  // 0010010w
  localparam logic [6:0] OP_IMM_GROUP   = 7'h40;  // 1000000w
  localparam logic [6:0] OP_TEST_RM     = 7'h42;  // 1000010w
  localparam logic [6:0] OP_UNARY_GROUP = 7'h7b;  // 1111011w
  localparam logic [6:0] OP_TEST_ACC    = 7'h54;  // 1010100w

  localparam logic [2:0] SUB_AND        = 3'h4;
  localparam logic [2:0] SUB_TEST       = 3'h0;
  localparam logic [1:0] MOD_REGISTER   = 2'h3;

  // clock counts
  localparam logic [3:0] CLK_SHIFT_REG  = 4'h3;
  localparam logic [3:0] CLK_SHIFT_MEM  = 4'h7;
  localparam logic [3:0] CLK_CARRY_REG  = 4'h9;
  localparam logic [3:0] CLK_CARRY_MEM  = 4'ha;
  localparam logic [3:0] CLK_LOGIC_REG  = 4'h2;
  localparam logic [3:0] CLK_AND_TO_MEM = 4'h7;
  localparam logic [3:0] CLK_AND_TO_REG = 4'h6;
  localparam logic [3:0] CLK_TEST_MEM   = 4'h5;

  typedef enum logic [2:0] {
    rotate_left, rotate_right, rotate_carry_left, rotate_carry_right,
    shift_left, shift_right_logical, shift_undefined, shift_right_arith
  } shift_op_field_t;

  typedef enum logic [3:0] {
    OPK_NONE, OPK_SHIFT, OPK_DSHL, OPK_DSHR, OPK_AND, OPK_TEST
  } op_kind_t;

  typedef enum logic [1:0] {
    CNT_NONE, CNT_ONE, CNT_COUNT_REG, CNT_IMM8
  } count_src_t;

  // bytes offered by the prefetch queue
  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
  } insn_bytes_t;

  // decoded result to the datapath
  typedef struct packed {
    logic            valid;
    op_kind_t        kind;
    shift_op_field_t shift_op;
    count_src_t      count_src;
    logic            mem_operand;
    logic            wide;
    logic            reg_is_dest;
    logic            flags_only;
    logic            has_modrm;
    logic            has_imm;
    logic [3:0]      clocks;
  } decode_t;

endpackage

// >>> shift_logic_decode.sv
`timescale 1ns/1ps

// Function
// - op field selects rotate/shift variant
// - 1101001w shifts by count register, 3/7
// - 1100000w uses 8-bit immediate count, 3/7
// - carry rotates take 9/10 clocks
// - 1101000w shifts by one, 3/7
// - 0f a5 double left by count, 3/7
// - 0f a4 double left by immediate, 3/7
// - 0f ad double right by count, 3/7
// - 0f ac double right by immediate, 3/7
// - AND to memory 7, from memory 6
// - immediate group sub 100 ANDs, 2/7
// - accumulator AND short form, 2 clocks
// - test 1000010w updates flags only, 2/5
// - 1111011w sub 000 tests immediate, 2/5
// - 1010100w tests accumulator, 2 clocks
module shift_logic_decode (
  input  wire logic                        sys_clk,   // core clock, 10 MHz
  input  wire logic                        sys_rst,   // async reset, active high
  input  wire logic                        insn_valid, // bytes below are a new opcode
  input  wire shift_logic_pkg::insn_bytes_t insn,      // first three opcode bytes
  output logic                             dec_valid, // decode result ready
  output shift_logic_pkg::decode_t         dec_out    // registered decode result
);
  import shift_logic_pkg::*;

  decode_t dec_next;
  decode_t dec_reg;
  logic [7:0] spec;
  logic       is_reg;

  // specifier byte sits after one or two opcode bytes
  always_comb begin
    spec = (insn.b0 == OP_ESCAPE) ? insn.b2 : insn.b1;
    is_reg = (spec[7:6] == MOD_REGISTER);
  end

  // pure decode; unknown opcodes leave valid low so other groups own them
  always_comb begin
    dec_next = '0;
    dec_next.kind = OPK_NONE;
    dec_next.shift_op = shift_op_field_t'(spec[5:3]);
    dec_next.count_src = CNT_NONE;
    dec_next.mem_operand = !is_reg;
    dec_next.wide = insn.b0[0];
    dec_next.has_modrm = 1'b1;
    if (insn.b0[7:1] == OP_SHIFT_ONE || insn.b0[7:1] == OP_SHIFT_CNT ||
        insn.b0[7:1] == OP_SHIFT_IMM) begin
      dec_next.kind = OPK_SHIFT;
      dec_next.valid = (dec_next.shift_op != shift_undefined); // field 110 is no shift
      if (insn.b0[7:1] == OP_SHIFT_ONE) begin
        dec_next.count_src = CNT_ONE;
      end else if (insn.b0[7:1] == OP_SHIFT_CNT) begin
        dec_next.count_src = CNT_COUNT_REG;
      end else begin
        dec_next.count_src = CNT_IMM8;
        dec_next.has_imm = 1'b1;
      end
      if (dec_next.shift_op == rotate_carry_left || dec_next.shift_op == rotate_carry_right) begin
        dec_next.clocks = is_reg ? CLK_CARRY_REG : CLK_CARRY_MEM;
      end else begin
        dec_next.clocks = is_reg ? CLK_SHIFT_REG : CLK_SHIFT_MEM;
      end
    end else if (insn.b0 == OP_ESCAPE && (insn.b1 == OP_DSHL_IMM ||
                 insn.b1 == OP_DSHL_CNT || insn.b1 == OP_DSHR_IMM ||
                 insn.b1 == OP_DSHR_CNT)) begin
      dec_next.valid = 1'b1;
      dec_next.wide = 1'b1;
      dec_next.kind = insn.b1[3] ? OPK_DSHR : OPK_DSHL;
      dec_next.count_src = insn.b1[0] ? CNT_COUNT_REG : CNT_IMM8;
      dec_next.has_imm = !insn.b1[0];
      dec_next.clocks = is_reg ? CLK_SHIFT_REG : CLK_SHIFT_MEM;
    end else if (insn.b0[7:2] == OP_AND_RR) begin
      dec_next.valid = 1'b1;
      dec_next.kind = OPK_AND;
      dec_next.reg_is_dest = insn.b0[1];
      if (is_reg) begin
        dec_next.clocks = CLK_LOGIC_REG;
      end else begin
        dec_next.clocks = insn.b0[1] ? CLK_AND_TO_REG : CLK_AND_TO_MEM;
      end
    end else if (insn.b0[7:1] == OP_IMM_GROUP && spec[5:3] == SUB_AND) begin
      dec_next.valid = 1'b1;
      dec_next.kind = OPK_AND;
      dec_next.has_imm = 1'b1;
      dec_next.clocks = is_reg ? CLK_LOGIC_REG : CLK_AND_TO_MEM;
    end else if (insn.b0[7:1] == OP_AND_ACC) begin
      dec_next.valid = 1'b1;
      dec_next.kind = OPK_AND;
      dec_next.has_modrm = 1'b0;
      dec_next.mem_operand = 1'b0;
      dec_next.has_imm = 1'b1;
      dec_next.reg_is_dest = 1'b1;
      dec_next.clocks = CLK_LOGIC_REG;
    end else if (insn.b0[7:1] == OP_TEST_RM ||
                 (insn.b0[7:1] == OP_UNARY_GROUP && spec[5:3] == SUB_TEST)) begin
      dec_next.valid = 1'b1;
      dec_next.kind = OPK_TEST;
      dec_next.flags_only = 1'b1;
      dec_next.has_imm = insn.b0[7:1] == OP_UNARY_GROUP;
      dec_next.clocks = is_reg ? CLK_LOGIC_REG : CLK_TEST_MEM;
    end else if (insn.b0[7:1] == OP_TEST_ACC) begin
      dec_next.valid = 1'b1;
      dec_next.kind = OPK_TEST;
      dec_next.flags_only = 1'b1;
      dec_next.has_modrm = 1'b0;
      dec_next.mem_operand = 1'b0;
      dec_next.has_imm = 1'b1;
      dec_next.clocks = CLK_LOGIC_REG;
    end
    if (!insn_valid) begin
      dec_next.valid = 1'b0;
    end
  end

  // result register; one cycle latency, every cycle a new opcode may arrive
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec_reg <= '0;
    end else begin
      dec_reg <= dec_next;
    end
  end

  assign dec_out = dec_reg;
  assign dec_valid = dec_reg.valid;

  // checks against the opcode bytes of the previous cycle
  sequence shift_cnt_reg_s;
    insn_valid && insn.b0[7:1] == OP_SHIFT_CNT && insn.b1[7:6] == MOD_REGISTER
      && insn.b1[5:4] != 2'h1 && insn.b1[5:3] != 3'h6;
  endsequence

  sequence carry_mem_s;
    insn_valid && insn.b0[7:1] == OP_SHIFT_ONE && insn.b1[7:6] != MOD_REGISTER
      && insn.b1[5:4] == 2'h1;
  endsequence

  shift_cnt_reg_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    shift_cnt_reg_s |=> dec_valid && dec_out.clocks == 4'h3 && dec_out.count_src == CNT_COUNT_REG)
    else $error("count-register shift timing wrong");

  carry_one_mem_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    carry_mem_s |=> dec_valid && dec_out.clocks == 4'ha && dec_out.count_src == CNT_ONE)
    else $error("carry rotate memory timing wrong");

  shift_field_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    insn_valid && insn.b0[7:1] == OP_SHIFT_IMM |=>
      dec_out.shift_op == shift_op_field_t'($past(insn.b1[5:3])) && dec_out.has_imm)
    else $error("shift field or immediate wrong");

  double_left_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    insn_valid && insn.b0 == OP_ESCAPE && insn.b1 == OP_DSHL_IMM && insn.b2[7:6] != 2'h3
      |=> dec_out.kind == OPK_DSHL && dec_out.clocks == 4'h7 && dec_out.has_imm)
    else $error("double left immediate wrong");

  double_right_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    insn_valid && insn.b0 == OP_ESCAPE && insn.b1 == OP_DSHR_CNT && insn.b2[7:6] == 2'h3
      |=> dec_out.kind == OPK_DSHR && dec_out.clocks == 4'h3 && !dec_out.has_imm)
    else $error("double right count wrong");

  and_from_mem_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    insn_valid && insn.b0[7:1] == 7'h11 && insn.b1[7:6] != 2'h3
      |=> dec_out.kind == OPK_AND && dec_out.clocks == 4'h6 && dec_out.reg_is_dest)
    else $error("and from memory timing wrong");

  test_imm_mem_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    insn_valid && insn.b0[7:1] == OP_UNARY_GROUP && insn.b1[5:3] == 3'h0
      && insn.b1[7:6] != 2'h3 |=> dec_out.flags_only && dec_out.clocks == 4'h5)
    else $error("test immediate memory timing wrong");

  acc_short_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    insn_valid && (insn.b0[7:1] == OP_AND_ACC || insn.b0[7:1] == OP_TEST_ACC)
      |=> dec_out.clocks == 4'h2 && !dec_out.has_modrm && dec_out.wide == $past(insn.b0[0]))
    else $error("accumulator short form wrong");

  // carry rotates stay slow even with a register operand
  carry_cnt_reg_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    insn_valid && insn.b0[7:1] == OP_SHIFT_CNT && insn.b1[7:6] == MOD_REGISTER
      && (insn.b1[5:3] == rotate_carry_left || insn.b1[5:3] == rotate_carry_right)
      |=> dec_valid && dec_out.clocks == CLK_CARRY_REG)
    else $error("carry rotate register timing wrong");

  shift_imm_mem_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    insn_valid && insn.b0[7:1] == OP_SHIFT_IMM && insn.b1[7:6] != MOD_REGISTER
      && insn.b1[5:3] == shift_left
      |=> dec_valid && dec_out.clocks == CLK_SHIFT_MEM && dec_out.count_src == CNT_IMM8)
    else $error("immediate shift memory timing wrong");

  double_left_cnt_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    insn_valid && insn.b0 == OP_ESCAPE && insn.b1 == OP_DSHL_CNT
      && insn.b2[7:6] != MOD_REGISTER
      |=> dec_valid && dec_out.kind == OPK_DSHL && dec_out.clocks == CLK_SHIFT_MEM
        && dec_out.count_src == CNT_COUNT_REG)
    else $error("double left count wrong");

  double_right_imm_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    insn_valid && insn.b0 == OP_ESCAPE && insn.b1 == OP_DSHR_IMM
      && insn.b2[7:6] == MOD_REGISTER
      |=> dec_valid && dec_out.kind == OPK_DSHR && dec_out.clocks == CLK_SHIFT_REG
        && dec_out.has_imm && dec_out.wide)
    else $error("double right immediate wrong");

  // direction and size bits must pass through untouched
  and_reg_reg_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    insn_valid && insn.b0[7:2] == OP_AND_RR && insn.b1[7:6] == MOD_REGISTER
      |=> dec_valid && dec_out.clocks == CLK_LOGIC_REG
        && dec_out.reg_is_dest == $past(insn.b0[1]) && dec_out.wide == $past(insn.b0[0]))
    else $error("and register timing wrong");

  and_imm_mem_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    insn_valid && insn.b0[7:1] == OP_IMM_GROUP && insn.b1[5:3] == SUB_AND
      && insn.b1[7:6] != MOD_REGISTER
      |=> dec_valid && dec_out.kind == OPK_AND && dec_out.clocks == CLK_AND_TO_MEM
        && dec_out.has_imm)
    else $error("and immediate memory timing wrong");

  test_rm_mem_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    insn_valid && insn.b0[7:1] == OP_TEST_RM && insn.b1[7:6] != MOD_REGISTER
      |=> dec_valid && dec_out.kind == OPK_TEST && dec_out.flags_only
        && dec_out.clocks == CLK_TEST_MEM && !dec_out.has_imm)
    else $error("test memory timing wrong");

  test_acc_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    insn_valid && insn.b0[7:1] == OP_TEST_ACC
      |=> dec_valid && dec_out.kind == OPK_TEST && dec_out.flags_only
        && !dec_out.mem_operand && dec_out.clocks == CLK_LOGIC_REG)
    else $error("test accumulator wrong");

  // field 110 must be refused so another group can claim it
  field_refused_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    insn_valid && (insn.b0[7:1] == OP_SHIFT_ONE || insn.b0[7:1] == OP_SHIFT_CNT
      || insn.b0[7:1] == OP_SHIFT_IMM) && insn.b1[5:3] == shift_undefined
      |=> !dec_valid)
    else $error("undefined shift field accepted");

endmodule

// >>> prefetch_model.sv
`timescale 1ns/1ps

module prefetch_model (
  input  wire logic                         sys_clk,    // core clock
  input  wire logic                         push,       // next slot holds an opcode
  input  wire shift_logic_pkg::insn_bytes_t push_bytes, // bytes for that slot
  output logic                              insn_valid, // offered to decoder
  output shift_logic_pkg::insn_bytes_t      insn        // opcode bytes offered
);
  import shift_logic_pkg::*;
  logic        v;
  insn_bytes_t b;
  initial begin
    insn_valid = 1'b0;
    insn = '0;
  end
  // one slot per cycle; idle slots invert the bytes shown, so stale data shows again after two idle slots
  always @(posedge sys_clk) begin
    v = push;
    b = push_bytes;
    #1;
    insn_valid = v;
    insn = v ? b : ~insn;
  end
endmodule

// >>> shift_rotate_logic_decode_tb.sv
`timescale 1ns/1ps

module shift_rotate_logic_decode_tb;
  import shift_logic_pkg::*;
  logic        sys_clk, sys_rst, en, insn_valid, dec_valid, pv, pr;
  insn_bytes_t nb, insn, pb;
  decode_t     dec_out, e;
  integer      seed, bad_count, check_count, i, r;
  logic [7:0]  b0_tab [14] = '{8'hd0, 8'hd3, 8'hc1, 8'h0f, 8'h20, 8'h21, 8'h22, 8'h23,
                              8'h24, 8'h81, 8'h84, 8'hf6, 8'ha9, 8'h30};
  logic [7:0]  ds_tab [4] = '{8'ha4, 8'ha5, 8'hac, 8'had};

  prefetch_model fetch (.sys_clk(sys_clk), .push(en), .push_bytes(nb),
                        .insn_valid(insn_valid), .insn(insn));
  shift_logic_decode DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .insn_valid(insn_valid),
                          .insn(insn), .dec_valid(dec_valid), .dec_out(dec_out));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // reference decode from the opcode tables, written independently of the design
  function automatic decode_t model(input insn_bytes_t x);
    decode_t d;
    logic [7:0] s;
    logic reg_op;
    d = '0;
    s = (x.b0 == 8'h0f) ? x.b2 : x.b1;
    reg_op = (s[7:6] == 2'h3);
    d.valid = 1'b1;
    d.mem_operand = !reg_op;
    d.wide = x.b0[0];
    d.has_modrm = 1'b1;
    if (x.b0[7:2] == 6'h34 || x.b0[7:1] == 7'h60) begin
      d.kind = OPK_SHIFT;
      d.shift_op = shift_op_field_t'(s[5:3]);
      d.count_src = !x.b0[4] ? CNT_IMM8 : (x.b0[1] ? CNT_COUNT_REG : CNT_ONE);
      d.has_imm = !x.b0[4];
      d.valid = (s[5:3] != 3'h6);
      d.clocks = (s[5:4] == 2'b01) ? (reg_op ? 4'h9 : 4'ha) : (reg_op ? 4'h3 : 4'h7);
    end else if (x.b0 == 8'h0f && x.b1[7:4] == 4'ha && x.b1[2:1] == 2'b10) begin
      d.kind = x.b1[3] ? OPK_DSHR : OPK_DSHL;
      d.count_src = x.b1[0] ? CNT_COUNT_REG : CNT_IMM8;
      d.has_imm = !x.b1[0];
      d.wide = 1'b1;
      d.clocks = reg_op ? 4'h3 : 4'h7;
    end else if (x.b0[7:2] == 6'h08) begin
      d.kind = OPK_AND;
      d.reg_is_dest = x.b0[1];
      d.clocks = reg_op ? 4'h2 : (x.b0[1] ? 4'h6 : 4'h7);
    end else if (x.b0[7:1] == 7'h12 || x.b0[7:1] == 7'h54) begin
      d.kind = x.b0[7] ? OPK_TEST : OPK_AND;
      d.flags_only = x.b0[7];
      d.reg_is_dest = !x.b0[7];
      d.has_modrm = 1'b0;
      d.has_imm = 1'b1;
      d.mem_operand = 1'b0;
      d.clocks = 4'h2;
    end else if (x.b0[7:1] == 7'h40 && s[5:3] == 3'h4) begin
      d.kind = OPK_AND;
      d.has_imm = 1'b1;
      d.clocks = reg_op ? 4'h2 : 4'h7;
    end else if (x.b0[7:1] == 7'h42 || (x.b0[7:1] == 7'h7b && s[5:3] == 3'h0)) begin
      d.kind = OPK_TEST;
      d.flags_only = 1'b1;
      d.has_imm = x.b0[4];
      d.clocks = reg_op ? 4'h2 : 4'h5;
    end else begin
      d.valid = 1'b0;
    end
    return d;
  endfunction

  task check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // capture what the decoder takes at an edge, judge what it registers at that edge
  always @(posedge sys_clk) begin
    pv = insn_valid;
    pb = insn;
    pr = sys_rst;
    #2;
    if (!sys_rst) begin
      e = (pv && !pr) ? model(pb) : '0;
      check("dec_valid", 4'(dec_valid), 4'(e.valid));
      if (e.valid) begin
        check("kind", 4'(dec_out.kind), 4'(e.kind));
        check("clocks", dec_out.clocks, e.clocks);
        check("mem", 4'(dec_out.mem_operand), 4'(e.mem_operand));
        check("count_src", 4'(dec_out.count_src), 4'(e.count_src));
        check("flags_only", 4'(dec_out.flags_only), 4'(e.flags_only));
        check("wide", 4'(dec_out.wide), 4'(e.wide));
        check("has_imm", 4'(dec_out.has_imm), 4'(e.has_imm));
        check("has_modrm", 4'(dec_out.has_modrm), 4'(e.has_modrm));
        check("reg_is_dest", 4'(dec_out.reg_is_dest), 4'(e.reg_is_dest));
        if (e.kind == OPK_SHIFT)
          check("shift_op", 4'(dec_out.shift_op), 4'(e.shift_op));
      end
    end
  end

  // watchdog: the run needs about 3010 cycles
  initial begin
    #(4000 * 100);
    bad_count++;
    complete_run();
  end

  initial begin
    seed = 22;
    bad_count = 0;
    check_count = 0;
    en = 1'b0;
    nb = '0;
    sys_rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    for (i = 0; i < 3000; i++) begin
      @(posedge sys_clk);
      #1;
      sys_rst = (i == 1500); // one mid-run reset
      r = $random(seed);
      en = (r[2:0] != 3'h0);
      nb = 24'($random(seed));
      if (i % 4 != 3) begin
        nb.b0 = b0_tab[r[6:3] % 14] ^ {7'h0, r[7]};
        if (nb.b0[7:1] == 7'h07)
          nb.b1 = ds_tab[r[9:8]];
      end
    end
    en = 1'b0;
    repeat (3) @(posedge sys_clk);
    complete_run();
  end
endmodule
